// file: design/mscn_pkg.sv
// Purpose: shared constants and types for the memory scan checker
// Assumes: apb slave with 32-bit data, one word per register
// Notes:   offsets are byte addresses
package mscn_pkg;
    localparam logic [11:0] ADDR_CTRL_A    = 12'h000;
    localparam logic [11:0] ADDR_CTRL_B    = 12'h004;
    localparam logic [11:0] ADDR_STATUS    = 12'h008;
    localparam logic [11:0] ADDR_DBG_STAT  = 12'h00c;
    localparam logic [11:0] ADDR_DBG_CTRL  = 12'h010;
    localparam int          BIT_ENABLE     = 0;
    localparam int          BIT_NONMASKABLE_TRIGGER_ENABLE      = 1;
    localparam int          BIT_SRESET     = 7;
    localparam int          BIT_BUSY       = 0;
    localparam int          BIT_OK         = 1;
    localparam int          BIT_DBG_HOLD   = 0;
    localparam int          BIT_DBG_INT    = 1;
    localparam int          BIT_DBG_DISC   = 2;
    localparam int          BIT_DBG_SRC    = 3;
    localparam logic [1:0]  SEC_BOOT       = 2'h0;
    localparam logic [1:0]  SEC_BOOT_APP   = 2'h1;
    localparam logic [1:0]  SEC_FULL       = 2'h2;
    localparam logic [15:0] CRC_PRESET     = 16'hffff;
    localparam logic [15:0] CRC_POLY       = 16'h1021;
    localparam int          START_DELAY    = 3;
    localparam int          FETCH_PERIOD   = 3;
    localparam int          CLK_MHZ        = 50;

    typedef struct packed {
        logic        nonmaskable_trigger_enable;
        logic        enable;
    } mscn_ctrl_a_t;

    typedef struct packed {
        logic [1:0]  mode;
        logic [1:0]  section_select;
    } mscn_ctrl_b_t;

    typedef struct packed {
        logic        req;
        logic [15:0] addr;
    } mscn_fetch_t;
endpackage : mscn_pkg

// file: design/mscn_scanner.sv
// Purpose: memory scan checker with crc-16 over program memory bytes
// Assumes: flash answers a word read with FLASH_VALID_I, any later cycle
// Notes:   debugger reaches the same registers on the same bus, marked by pwdata bit 31
// Notes on behaviour
// R1: crc sixteen with taps sixteen twelve five zero
// R2: checksum preset all ones each scan
// R3: bytes from zero upward, msb first
// R4: pass only if last two bytes match
// R5: match sets pass bit, mismatch shows fail
// R6: mismatch raises nmi when enabled
// R7: section boot, boot plus app, or full
// R8: scan pauses in every sleep mode
// R9: debugger access holds checker disabled
// R10: held scan restarts on internal access or disconnect
// R11: busy stays one while held, no reads
// R12: debug status copy read without disabling
// R13: debugger busy zero aborts the scan
// R14: debugger busy one schedules one scan later
// R15: busy blocks second control and nmi enable writes
// R16: debugger ok zero raises nmi when enabled
// R17: after nmi every register write rejected; the code still takes ADDR_DBG_CTRL writes
// R18: debugger ok one reads one when idle
// R19: debugger control writes act like cpu writes
// R20: everything runs on the peripheral clock
// R21: scan starts three cycles after enable
// R22: priority flash access, word every third cycle
// R23: failure clears ok, nmi sticks until reset
// R24: full scan checksum at last two addresses
// R25: section ends come in as configuration
module mscn_scanner #(
    parameter int ADDR_W = 16
) (
    input  wire logic                 CLK_SYS_I,
    input  wire logic                 RESET_N_I,
    input  wire logic [11:0]          PADDR_I,
    input  wire logic                 PSEL_I,
    input  wire logic                 PENABLE_I,
    input  wire logic                 PWRITE_I,
    input  wire logic [31:0]          PWDATA_I,
    output logic      [31:0]          PRDATA_O,
    output logic                      PREADY_O,
    output logic                      PSLVERR_O,
    input  wire logic                 SLEEP_I,
    input  wire logic [ADDR_W-1:0]    BOOT_END_I,
    input  wire logic [ADDR_W-1:0]    APP_END_I,
    input  wire logic [ADDR_W-1:0]    MEM_LAST_I,
    output mscn_pkg::mscn_fetch_t     FETCH_O,
    input  wire logic                 FLASH_VALID_I,
    input  wire logic [15:0]          FLASH_DATA_I,
    output logic                      CPU_STALL_O,
    output logic                      NMI_O
);
    import mscn_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_FETCH, ST_DONE} mscn_state_t;

    mscn_state_t       state_q;
    mscn_ctrl_a_t      ctrl_a_q;
    mscn_ctrl_b_t      ctrl_b_q;
    logic              busy_q;
    logic              ok_q;
    logic              nmi_q;
    logic              dbg_hold_q;
    logic              pend_q;
    logic [15:0]       crc_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] end_q;
    logic [1:0]        dly_q;
    logic [1:0]        gap_q;
    logic              req_q;
    logic [15:0]       stored_q;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              slverr_q;
    logic              sleep_s1_q;
    logic              sleep_q;

    localparam logic [1:0] DLY_LOAD = 2'(START_DELAY - 1);
    // request and answer already take three cycles of each fetch period
    localparam logic [1:0] GAP_LOAD = 2'(FETCH_PERIOD - 3);

    // apb access qualifiers; debugger and cpu share the bus, pwdata bit 31 marks debugger
    logic acc;
    logic wr;
    logic dbg;
    logic start_req;
    logic abort_req;
    logic sreset;
    logic run;
    assign acc = PSEL_I && PENABLE_I && !pready_q;
    assign wr  = acc && PWRITE_I && !nmi_q; // [R17]
    assign dbg = PWDATA_I[31];

    // two-stage sync; sleep comes from the power controller domain
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            sleep_s1_q <= 1'b0;
            sleep_q    <= 1'b0;
        end else begin
            sleep_s1_q <= SLEEP_I;
            sleep_q    <= sleep_s1_q;
        end
    end

    // scan proceeds only while awake and not held by the debugger
    assign run = !sleep_q && !dbg_hold_q; // [R8] [R9] [R11]

    assign sreset = wr && PADDR_I == ADDR_CTRL_A && PWDATA_I[BIT_SRESET]
                    && !(ctrl_a_q.nonmaskable_trigger_enable && busy_q);
    assign start_req = (wr && PADDR_I == ADDR_CTRL_A && PWDATA_I[BIT_ENABLE]) // [R19]
                    || (wr && dbg && PADDR_I == ADDR_STATUS && PWDATA_I[BIT_BUSY]); // [R14]
    assign abort_req = wr && dbg && PADDR_I == ADDR_STATUS && !PWDATA_I[BIT_BUSY]; // [R13]

    // debugger hold: an ADDR_DBG_CTRL write loads the hold bit; internal access, disconnect or an ADDR_DBG_STAT access releases
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            dbg_hold_q <= 1'b0;
        end else if (acc && PADDR_I == ADDR_DBG_CTRL && PWRITE_I) begin
            if (PWDATA_I[BIT_DBG_INT] || PWDATA_I[BIT_DBG_DISC]) begin
                dbg_hold_q <= 1'b0; // [R10]
            end else begin
                dbg_hold_q <= PWDATA_I[BIT_DBG_HOLD]; // [R9]
            end
        end else if (acc && PADDR_I == ADDR_DBG_STAT) begin
            dbg_hold_q <= 1'b0; // [R12]
        end
    end

    // control registers
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            ctrl_a_q <= '0;
            ctrl_b_q <= '0;
        end else if (sreset) begin
            ctrl_a_q.enable <= 1'b0; // nonmaskable_trigger_enable survives soft reset
            ctrl_b_q        <= '0;
        end else if (wr && PADDR_I == ADDR_CTRL_A) begin
            ctrl_a_q.enable <= PWDATA_I[BIT_ENABLE];
            if (!busy_q && PWDATA_I[BIT_NONMASKABLE_TRIGGER_ENABLE]) begin
                ctrl_a_q.nonmaskable_trigger_enable <= 1'b1; // [R15] [R23]
            end
        end else if (wr && PADDR_I == ADDR_CTRL_B && !busy_q) begin // [R15] [R19]
            ctrl_b_q.mode           <= PWDATA_I[5:4];
            ctrl_b_q.section_select <= PWDATA_I[1:0];
        end
    end

    // section end selection from configuration
    function automatic logic [ADDR_W-1:0] sec_end(input logic [1:0] sel);
        case (sel)
            SEC_BOOT:     sec_end = BOOT_END_I - ADDR_W'(1); // [R7] [R25]
            SEC_BOOT_APP: sec_end = APP_END_I - ADDR_W'(1);
            default:      sec_end = MEM_LAST_I; // [R24]
        endcase
    endfunction : sec_end

    // crc of one byte, msb first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? CRC_POLY : 16'h0000); // [R1] [R3]
        end
        return r;
    endfunction : crc_byte

    // scan engine
    logic last_word;
    assign last_word = (addr_q + ADDR_W'(1)) == end_q;
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I || sreset) begin
            state_q  <= ST_IDLE;
            busy_q   <= 1'b0;
            pend_q   <= 1'b0;
            crc_q    <= CRC_PRESET;
            addr_q   <= '0;
            end_q    <= '0;
            dly_q    <= '0;
            gap_q    <= '0;
            req_q    <= 1'b0;
            stored_q <= '0;
        end else if (abort_req) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
            pend_q  <= 1'b0;
            req_q   <= 1'b0;
        end else if (start_req && state_q == ST_IDLE) begin
            state_q <= ST_WAIT;
            busy_q  <= 1'b1;
            dly_q   <= DLY_LOAD;
            pend_q  <= 1'b0;
        end else if (dbg_hold_q && busy_q) begin
            if (state_q != ST_WAIT) begin
                pend_q <= 1'b1; // [R10] restart on release
            end
            // an open fetch is finished and dropped, never cut mid-handshake
            req_q <= req_q && !FLASH_VALID_I; // [R11]
        end else if (pend_q) begin
            pend_q  <= 1'b0;
            state_q <= ST_WAIT;
            dly_q   <= DLY_LOAD;
        end else if (run) begin
            case (state_q)
                ST_IDLE: begin
                    req_q <= 1'b0;
                end
                ST_WAIT: begin
                    if (dly_q == 2'h0) begin // [R21]
                        state_q <= ST_FETCH;
                        crc_q   <= CRC_PRESET; // [R2]
                        addr_q  <= '0;
                        end_q   <= sec_end(ctrl_b_q.section_select);
                        gap_q   <= GAP_LOAD;
                    end else begin
                        dly_q <= dly_q - 2'h1;
                    end
                end
                ST_FETCH: begin
                    if (req_q && FLASH_VALID_I) begin
                        req_q <= 1'b0;
                        if (last_word) begin
                            stored_q <= {FLASH_DATA_I[7:0], FLASH_DATA_I[15:8]};
                            state_q  <= ST_DONE;
                        end else begin
                            crc_q  <= crc_byte(crc_byte(crc_q, FLASH_DATA_I[7:0]),
                                               FLASH_DATA_I[15:8]); // [R3]
                            addr_q <= addr_q + ADDR_W'(2);
                            gap_q  <= GAP_LOAD;
                        end
                    end else if (!req_q) begin
                        if (gap_q == 2'h0) begin
                            req_q <= 1'b1; // [R22]
                        end else begin
                            gap_q <= gap_q - 2'h1;
                        end
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // pass flag and sticky nmi; failure wins over debugger writes
    logic fail_now;
    logic pass_now;
    assign pass_now = run && !dbg_hold_q && state_q == ST_DONE && stored_q == crc_q; // [R4]
    assign fail_now = run && !dbg_hold_q && state_q == ST_DONE && stored_q != crc_q;
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            ok_q  <= 1'b0;
            nmi_q <= 1'b0;
        end else begin
            if (fail_now) begin
                ok_q <= 1'b0; // [R5] [R23]
            end else if (pass_now) begin
                ok_q <= 1'b1; // [R5]
            end else if (sreset) begin
                ok_q <= 1'b0;
            end else if (wr && dbg && PADDR_I == ADDR_STATUS) begin
                ok_q <= PWDATA_I[BIT_OK] && !busy_q; // [R18]
            end
            if (ctrl_a_q.nonmaskable_trigger_enable && (fail_now
                || (wr && dbg && PADDR_I == ADDR_STATUS && !PWDATA_I[BIT_OK]))) begin
                nmi_q <= 1'b1; // [R6] [R16] [R23]
            end
        end
    end

    // apb read and answer, one wait cycle per access
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            slverr_q <= 1'b0;
        end else begin
            pready_q <= acc;
            slverr_q <= 1'b0;
            prdata_q <= '0;
            if (acc) begin
                case (PADDR_I)
                    ADDR_CTRL_A:   prdata_q <= {30'h0, ctrl_a_q.nonmaskable_trigger_enable, ctrl_a_q.enable};
                    ADDR_CTRL_B:   prdata_q <= {26'h0, ctrl_b_q.mode, 2'h0,
                                                ctrl_b_q.section_select};
                    ADDR_STATUS,
                    ADDR_DBG_STAT: prdata_q <= {30'h0, ok_q, busy_q}; // [R12]
                    ADDR_DBG_CTRL: prdata_q <= {31'h0, dbg_hold_q};
                    default:       slverr_q <= 1'b1;
                endcase
            end
        end
    end

    // fetch port; address stays registered
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            CPU_STALL_O <= 1'b0;
            NMI_O       <= 1'b0;
        end else begin
            CPU_STALL_O <= busy_q && state_q != ST_WAIT && (run || req_q); // [R22]
            NMI_O       <= nmi_q;
        end
    end

    assign FETCH_O.req  = req_q; // [R20]
    assign FETCH_O.addr = addr_q;
    assign PRDATA_O     = prdata_q;
    assign PREADY_O     = pready_q;
    assign PSLVERR_O    = slverr_q;
endmodule : mscn_scanner

// file: tb/mscn_flash_model.sv
// Purpose: behavioural program flash read port
// Assumes: byte address of an even word, answer after a wait
// Notes:   idle data toggles so a stale word is never taken as fresh
module mscn_flash_model (
    input  wire logic                  clk_i,
    input  wire logic                  slow_i,
    input  wire mscn_pkg::mscn_fetch_t fetch_i,
    output logic                       valid_o,
    output logic [15:0]                data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import mscn_pkg::*;
    logic [7:0] mem [0:31];
    int         wait_q = 0;
    initial valid_o = 1'b0;
    initial data_o = 16'h0000;
    initial for (int i = 0; i < 32; i++) mem[i] = 8'(i * 29 + 7);
    // low byte in [7:0], checksum high byte stored first
    always @(posedge clk_i) begin
        valid_o <= 1'b0;
        data_o  <= ~data_o;
        if (fetch_i.req && !valid_o) begin
            if (wait_q >= (slow_i ? 4 : 0)) begin
                valid_o <= 1'b1;
                data_o  <= {mem[fetch_i.addr[4:0] + 5'd1], mem[fetch_i.addr[4:0]]};
                wait_q  <= 0;
            end else begin
                wait_q <= wait_q + 1;
            end
        end
    end
endmodule : mscn_flash_model

// file: tb/mscn_scanner_chk.sv
// Purpose: port checks for the memory scan checker
// Assumes: one clock, sync active-low reset
// Notes:   the bench never holds the debugger around an enable write
module mscn_scanner_chk (
    input wire logic                  CLK_SYS_I,
    input wire logic                  RESET_N_I,
    input wire logic [11:0]           PADDR_I,
    input wire logic                  PSEL_I,
    input wire logic                  PENABLE_I,
    input wire logic                  PWRITE_I,
    input wire logic [31:0]           PWDATA_I,
    input wire logic                  PREADY_O,
    input wire logic                  PSLVERR_O,
    input wire logic                  SLEEP_I,
    input wire mscn_pkg::mscn_fetch_t FETCH_O,
    input wire logic                  FLASH_VALID_I,
    input wire logic                  CPU_STALL_O,
    input wire logic                  NMI_O
);
    timeunit 1ns;
    timeprecision 1ns;
    import mscn_pkg::*;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);
    logic acc;
    logic go;
    assign acc = PSEL_I && PENABLE_I && !PREADY_O;
    // sleep or a running scan would delay the start legally
    assign go  = acc && PWRITE_I && PADDR_I == ADDR_CTRL_A && PWDATA_I[BIT_ENABLE]
                 && !CPU_STALL_O && !NMI_O && !SLEEP_I;
    a_ready_wait: assert property (acc |=> PREADY_O && $past(PADDR_I) == PADDR_I)
        else $error("ready missing after access");
    a_err_unmapped: assert property (acc && PADDR_I > ADDR_DBG_CTRL |=> PSLVERR_O)
        else $error("unmapped access without error");
    a_fetch_hold: assert property (FETCH_O.req && !FLASH_VALID_I |=>
        FETCH_O.req && $stable(FETCH_O.addr)) else $error("fetch request dropped");
    a_fetch_stall: assert property (FETCH_O.req |-> CPU_STALL_O)
        else $error("fetch without cpu stall");
    a_fetch_gap: assert property (FETCH_O.req && FLASH_VALID_I |=> !FETCH_O.req)
        else $error("fetch not spaced");
    a_start_fetch: assert property (go |-> ##[2:5] FETCH_O.req)
        else $error("scan did not start");
    a_cpu_runs: assert property (go |=> !CPU_STALL_O [*2])
        else $error("cpu stalled in start delay");
    a_nmi_sticky: assert property (NMI_O |=> NMI_O)
        else $error("nmi dropped");
    a_sleep_pause: assert property (SLEEP_I [*4] |-> !$rose(FETCH_O.req))
        else $error("fetch while asleep");
endmodule : mscn_scanner_chk
bind mscn_scanner mscn_scanner_chk u_chk (.*);

// file: tb/mscn_scanner_tb_top.sv
// Purpose: self-checking bench for the memory scan checker
// Assumes: apb master, flash model answers every request
// Notes:   boot ends at 8, application at 16, memory holds 32 bytes
module mscn_scanner_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mscn_pkg::*;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        sleep = 0, slow = 0, err, pready, pslverr, fvalid, stall, nmi;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [15:0] fdata;
    mscn_fetch_t fetch;
    int          fail_count = 0, checks_done = 0;
    initial forever #10 clk = ~clk;
    mscn_scanner u_dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .PADDR_I(paddr), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .SLEEP_I(sleep), .BOOT_END_I(16'h0008),
        .APP_END_I(16'h0010), .MEM_LAST_I(16'h001f), .FETCH_O(fetch), .FLASH_VALID_I(fvalid),
        .FLASH_DATA_I(fdata), .CPU_STALL_O(stall), .NMI_O(nmi));
    mscn_flash_model u_flash (.clk_i(clk), .slow_i(slow), .fetch_i(fetch), .valid_o(fvalid),
        .data_o(fdata));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic wait_idle;
        do apb(1'b0, ADDR_STATUS, '0); while (rd[BIT_BUSY] !== 1'b0);
    endtask : wait_idle
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    // checksum over all bytes before the last two, msb first
    task automatic seal(input int e);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < e - 2; i++)
            for (int b = 7; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ u_flash.mem[i][b]) ? 16'h1021 : 16'h0);
        u_flash.mem[e-2] = c[15:8];
        u_flash.mem[e-1] = c[7:0];
    endtask : seal
    task automatic run_scan(input logic [1:0] s, input logic [7:0] a, input logic [1:0] st);
        wr(ADDR_CTRL_B, {30'h0, s});
        wr(ADDR_CTRL_A, {24'h0, a});
        repeat (4) @(posedge clk);
        wait_idle;
        chk("status", rd[1:0], st);
    endtask : run_scan
    task automatic t_regs;
        for (int a = 0; a < 12; a += 4) begin
            apb(1'b0, 12'(a), '0);
            chk("reset_val", rd[7:0], 8'h00);
        end
        apb(1'b0, 12'h020, '0);
        chk("slverr", err, 1'b1);
        wr(ADDR_CTRL_B, 32'h8000_0001);
        apb(1'b0, ADDR_CTRL_B, '0);
        chk("dbg_ctrl_b", rd[1:0], 2'h1);
        wr(ADDR_STATUS, 32'h8000_0002);
        apb(1'b0, ADDR_STATUS, '0);
        chk("ok_forced", rd[1:0], 2'h2);
    endtask : t_regs
    task automatic t_sections;
        logic [1:0] secs [3] = '{SEC_BOOT, SEC_BOOT_APP, SEC_FULL};
        foreach (secs[i]) begin
            slow <= (i == 2);
            run_scan(secs[i], 8'h01, 2'h2);
        end
        slow <= 1'b0;
    endtask : t_sections
    task automatic t_sleep;
        sleep <= 1'b1;
        wr(ADDR_CTRL_A, 32'h1);
        repeat (100) @(posedge clk);
        apb(1'b0, ADDR_STATUS, '0);
        chk("asleep_busy", rd[BIT_BUSY], 1'b1);
        sleep <= 1'b0;
        wait_idle;
        chk("woke_ok", rd[1:0], 2'h2);
    endtask : t_sleep
    task automatic t_hold(input int m);
        wr(ADDR_CTRL_A, 32'h1);
        wr(ADDR_DBG_CTRL, 32'h1);
        repeat (80) @(posedge clk);
        apb(1'b0, ADDR_STATUS, '0);
        chk("held_busy", rd[BIT_BUSY], 1'b1);
        chk("held_req", fetch.req, 1'b0);
        wr(ADDR_CTRL_B, {30'h0, SEC_BOOT});
        apb(1'b0, ADDR_CTRL_B, '0);
        chk("locked", rd[1:0], SEC_FULL);
        if (m == 2) begin
            apb(1'b0, ADDR_DBG_STAT, '0);
            chk("dbg_busy", rd[BIT_BUSY], 1'b1);
        end else begin
            wr(ADDR_DBG_CTRL, 32'(2 << m));
        end
        wait_idle;
        chk("restart_ok", rd[1:0], 2'h2);
    endtask : t_hold
    task automatic t_abort;
        wr(ADDR_CTRL_A, 32'h1);
        wr(ADDR_DBG_CTRL, 32'h1);
        wr(ADDR_STATUS, 32'h8000_0000);
        wr(ADDR_DBG_CTRL, 32'h2);
        repeat (10) @(posedge clk);
        apb(1'b0, ADDR_STATUS, '0);
        chk("aborted", rd[BIT_BUSY], 1'b0);
        wr(ADDR_DBG_CTRL, 32'h1);
        wr(ADDR_STATUS, 32'h8000_0001);
        wr(ADDR_DBG_CTRL, 32'h4);
        apb(1'b0, ADDR_STATUS, '0);
        chk("sched_busy", rd[BIT_BUSY], 1'b1);
        wait_idle;
        chk("sched_ok", rd[1:0], 2'h2);
    endtask : t_abort
    task automatic t_fail;
        u_flash.mem[0] = ~u_flash.mem[0];
        run_scan(SEC_BOOT, 8'h01, 2'h0);
        chk("quiet_nmi", nmi, 1'b0);
        wr(ADDR_CTRL_A, 32'h2);
        wr(ADDR_STATUS, 32'h8000_0000);
        repeat (2) @(posedge clk);
        chk("dbg_nmi", nmi, 1'b1);
        wr(ADDR_CTRL_B, {30'h0, SEC_FULL});
        apb(1'b0, ADDR_CTRL_B, '0);
        chk("frozen", rd[1:0], SEC_BOOT);
        do_reset;
        run_scan(SEC_BOOT, 8'h03, 2'h0);
        chk("fail_nmi", nmi, 1'b1);
    endtask : t_fail
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    initial begin
        do_reset;
        seal(8);
        seal(16);
        seal(32);
        t_regs;
        t_sections;
        t_sleep;
        for (int m = 0; m < 3; m++) t_hold(m);
        t_abort;
        t_fail;
        end_sim;
    end
    // a stuck handshake would otherwise hang the run
    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        end_sim;
    end
endmodule : mscn_scanner_tb_top
